// ==== hw/orc_pkg.sv ====
// Package: offsets, field layout, reset values and timing for the revision/control register bank
package orc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  REV_OFFSET     = 8'h00;
  localparam logic [7:0]  CTRL_OFFSET    = 8'h04;
  localparam logic [7:0]  REV_VALUE      = 8'h10;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // ==========================================================================
  // Control field positions
  localparam int SVC_RATIO_LSB   = 0;
  localparam int PERIODIC_EN_BIT = 2;
  localparam int ISO_EN_BIT      = 3;
  localparam int CONTROL_EN_BIT  = 4;
  localparam int BULK_EN_BIT     = 5;
  localparam int FS_LSB          = 6;
  localparam int ROUTE_BIT       = 8;
  localparam int WAKE_CONN_BIT   = 9;
  localparam int WAKE_EN_BIT     = 10;
  localparam int RSVD_LSB        = 11;

  // ==========================================================================
  // Functional state encoding
  localparam logic [1:0] FS_RESET       = 2'h0;
  localparam logic [1:0] FS_RESUME      = 2'h1;
  localparam logic [1:0] FS_OPERATIONAL = 2'h2;
  localparam logic [1:0] FS_SUSPEND     = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int SOF_DELAY_US   = 1000;
  localparam int SOF_DELAY_CYC  = (CLK_HZ / 1_000_000) * SOF_DELAY_US;

  // ==========================================================================
  // Bus carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } orc_req_t;

  typedef struct packed {
    logic [5:0] list_ctrl;
    logic [1:0] functional_state;
    logic       interrupt_routing_select;
    logic       remote_wake_connected;
    logic       remote_wake_enable;
  } orc_ctrl_t;

endpackage

// ==== hw/orc_regs.sv ====
// Revision and host control registers of the host controller
//
// Summary of operation
// - The revision register reads 10h in bits 7 to 0, zeros above, and ignores writes.
// - Only the functional state is ever changed by the controller itself; wake-up-connected changes only by driver write or hardware reset.
// - Remote wake-up is signalled while remote wake enable and the resume-detected flag are both set.
// - Remote wake enable has no influence on interrupt generation.
// - Hardware reset clears wake-up-connected; software reset leaves it alone.
// - Functional state encodes reset 00b, resume 01b, operational 10b, suspend 11b.
// - Start-of-frame generation begins 1 ms after entering operational from another state.
// - The controller moves suspend to resume on downstream resume signalling, only from suspend.
// - Interrupt routing bit clear sends status interrupts to the bus interrupt, set sends them to SMI.
`timescale 1ns/100ps

module orc_regs (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               soft_reset,
  input  wire orc_pkg::orc_req_t  req,
  input  wire logic               resume_detected,
  input  wire logic               downstream_resume,
  input  wire logic               status_irq,
  output logic [31:0]             rdata,
  output logic                    rvalid,
  output orc_pkg::orc_ctrl_t      ctrl,
  output logic                    sof_enable,
  output logic                    remote_wakeup,
  output logic                    host_irq,
  output logic                    smi_irq
);
  import orc_pkg::*;

  // ==========================================================================
  // Address decode and read-back packing
  function automatic logic hits_rev(input logic [7:0] addr);
    return addr == REV_OFFSET;
  endfunction

  function automatic logic hits_ctrl(input logic [7:0] addr);
    return addr == CTRL_OFFSET;
  endfunction

  // Reserved bits are never stored, so they always read back as zero
  function automatic logic [31:0] pack_ctrl(
    input logic [5:0] lists,
    input logic [1:0] state,
    input logic       route,
    input logic       conn,
    input logic       wake
  );
    return {21'h000000, wake, conn, route, state, lists};
  endfunction

  // ==========================================================================
  // Control register fields
  logic [5:0]  list_reg;
  logic [1:0]  fs_reg;
  logic        route_reg;
  logic        wake_conn_reg;
  logic        wake_en_reg;
  logic        ctrl_wr;
  logic        field_clear;
  logic [31:0] ctrl_word;

  assign ctrl_wr     = req.wr && hits_ctrl(req.addr);
  assign field_clear = !rst_n || soft_reset;

  // List enables and service ratio: plain read-write bits, one flop each
  for (genvar b = SVC_RATIO_LSB; b <= BULK_EN_BIT; b++) begin : g_list_bit
    always_ff @(posedge clk) begin
      if (field_clear) begin
        list_reg[b - SVC_RATIO_LSB] <= CTRL_RESET[b];
      end else if (ctrl_wr) begin
        list_reg[b - SVC_RATIO_LSB] <= req.wdata[b];
      end
    end
  end

  // Routing doubles as an ownership tag, so a software reset leaves it alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route_reg <= CTRL_RESET[ROUTE_BIT];
    end else if (ctrl_wr) begin
      route_reg <= req.wdata[ROUTE_BIT];
    end
  end

  // Cleared by either reset; only the driver ever sets it
  always_ff @(posedge clk) begin
    if (field_clear) begin
      wake_en_reg <= CTRL_RESET[WAKE_EN_BIT];
    end else if (ctrl_wr) begin
      wake_en_reg <= req.wdata[WAKE_EN_BIT];
    end
  end

  // Survives the software reset so firmware setup is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_conn_reg <= CTRL_RESET[WAKE_CONN_BIT];
    end else if (ctrl_wr) begin
      wake_conn_reg <= req.wdata[WAKE_CONN_BIT];
    end
  end

  // Driver write has priority over the hardware resume move
  always_ff @(posedge clk) begin
    if (field_clear) begin
      fs_reg <= FS_RESET;
    end else if (ctrl_wr) begin
      fs_reg <= req.wdata[FS_LSB +: 2];
    end else if (fs_reg == FS_SUSPEND && downstream_resume) begin
      fs_reg <= FS_RESUME;
    end
  end

  // ==========================================================================
  // Start-of-frame delay after entering operational
  logic [15:0] sof_cnt_reg;
  logic        fs_oper_d_reg;
  logic        fs_oper;

  assign fs_oper = (fs_reg == FS_OPERATIONAL);

  // Entry detector resets to the reset state's level, so no false entry follows reset
  always_ff @(posedge clk) begin
    if (field_clear) begin
      fs_oper_d_reg <= 1'b0;
    end else begin
      fs_oper_d_reg <= fs_oper;
    end
  end

  // Counts edges since entry; 16 bits cover the whole wait
  always_ff @(posedge clk) begin
    if (field_clear || !fs_oper) begin
      sof_cnt_reg <= 16'h0000;
    end else if (!fs_oper_d_reg) begin
      sof_cnt_reg <= 16'h0001;
    end else if (!sof_enable) begin
      sof_cnt_reg <= sof_cnt_reg + 16'h0001;
    end
  end

  // Rewriting operational while already running does not restart the wait
  always_ff @(posedge clk) begin
    if (field_clear || !fs_oper) begin
      sof_enable <= 1'b0;
    end else if (fs_oper_d_reg && !sof_enable && sof_cnt_reg == 16'(SOF_DELAY_CYC - 1)) begin
      sof_enable <= 1'b1;
    end
  end

  // ==========================================================================
  // Wake-up and interrupt routing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remote_wakeup <= 1'b0;
    end else begin
      remote_wakeup <= wake_en_reg && resume_detected;
    end
  end

  // Enable bit deliberately absent from the interrupt path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= status_irq && !route_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smi_irq <= 1'b0;
    end else begin
      smi_irq <= status_irq && route_reg;
    end
  end

  // ==========================================================================
  // Read path and outputs
  assign ctrl_word = pack_ctrl(list_reg, fs_reg, route_reg, wake_conn_reg, wake_en_reg);

  // One-cycle answer strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
    end
  end

  // Data holds after the answer until the next read, so a slow driver still sees it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      if (hits_rev(req.addr)) begin
        rdata <= {24'h000000, REV_VALUE};
      end else if (hits_ctrl(req.addr)) begin
        rdata <= ctrl_word;
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end

  // Mirror of the fields for the rest of the controller, one clock behind
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl <= '{list_ctrl:                list_reg,
                functional_state:         fs_reg,
                interrupt_routing_select: route_reg,
                remote_wake_connected:    wake_conn_reg,
                remote_wake_enable:       wake_en_reg};
    end
  end

endmodule // orc_regs

// ==== verification/orc_host_model.sv ====
// Host driver model: single-word register reads and writes
`timescale 1ns/100ps
module orc_host_model (
  input wire logic        clk,
  input wire logic [31:0] rdata,
  output orc_pkg::orc_req_t req
);
  import orc_pkg::*;
  initial req = '0;
  // Reserved bits always go out as zero, wake bits as the caller asks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1 req = {2'b01, a, d & 32'h0000_07FF};
    @(posedge clk) #1 req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) #1 req = {2'b10, a, 32'h0000_0000};
    @(posedge clk) #1 req = '0;
    d = rdata;
  endtask
endmodule // orc_host_model

// ==== verification/orc_regs_assertions.sv ====
// Checker for the revision/control register bank
`timescale 1ns/100ps
module orc_regs_assertions (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               soft_reset,
  input wire orc_pkg::orc_req_t  req,
  input wire logic               resume_detected,
  input wire logic               status_irq,
  input wire logic [31:0]        rdata,
  input wire logic               rvalid,
  input wire orc_pkg::orc_ctrl_t ctrl,
  input wire logic               sof_enable,
  input wire logic               remote_wakeup,
  input wire logic               host_irq,
  input wire logic               smi_irq
);
  import orc_pkg::*;
  int          run_reg;
  logic [31:0] w1_reg;
  logic [31:0] w2_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Helpers
  always_ff @(posedge clk) begin
    if (!rst_n || ctrl.functional_state != FS_OPERATIONAL) run_reg <= 0;
    else if (run_reg < 65535) run_reg <= run_reg + 1;
  end
  // Ctrl follows write data by two edges
  always_ff @(posedge clk) begin
    w1_reg <= req.wdata;
    w2_reg <= w1_reg;
  end
  rev_read_a: assert property ($past(req.rd && req.addr == REV_OFFSET) |-> rdata == {24'h00, REV_VALUE})
    else $error("revision read wrong");
  read_answer_a: assert property (rvalid == $past(req.rd))
    else $error("read answer timing wrong");
  ctrl_write_a: assert property ($past(req.wr && req.addr == CTRL_OFFSET && !soft_reset, 2)
    |-> ctrl == {w2_reg[5:0], w2_reg[7:6], w2_reg[8], w2_reg[9], w2_reg[10]})
    else $error("control write not stored");
  hold_fields_a: assert property ($past(rst_n && !req.wr && !soft_reset, 2)
    |-> $stable({ctrl.list_ctrl, ctrl.interrupt_routing_select, ctrl.remote_wake_enable}))
    else $error("control field changed by itself");
  wake_signal_a: assert property ($past(rst_n)
    |-> remote_wakeup == (ctrl.remote_wake_enable && $past(resume_detected)))
    else $error("remote wakeup wrong");
  host_route_a: assert property ($past(rst_n)
    |-> host_irq == ($past(status_irq) && !ctrl.interrupt_routing_select))
    else $error("bus interrupt routing wrong");
  smi_route_a: assert property ($past(rst_n)
    |-> smi_irq == ($past(status_irq) && ctrl.interrupt_routing_select))
    else $error("smi routing wrong");
  sof_delay_a: assert property ($rose(sof_enable)
    |-> run_reg >= SOF_DELAY_CYC - 2 && run_reg <= SOF_DELAY_CYC + 1)
    else $error("frame start delay wrong");
endmodule // orc_regs_assertions
bind orc_regs orc_regs_assertions chk (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .req(req),
  .resume_detected(resume_detected), .status_irq(status_irq), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
  .sof_enable(sof_enable), .remote_wakeup(remote_wakeup), .host_irq(host_irq), .smi_irq(smi_irq));

// ==== verification/tb.sv ====
// Testbench for the revision/control register bank
`timescale 1ns/100ps
module tb;
  import orc_pkg::*;
  logic        clk, rst_n, soft_reset, resume_detected, downstream_resume, status_irq;
  logic        rvalid, sof_enable, remote_wakeup, host_irq, smi_irq;
  logic [31:0] rdata, d;
  orc_req_t    req;
  orc_ctrl_t   ctrl;
  int          err_total = 0, check_count = 0, cyc = 0, t0 = 0;
  orc_host_model host (.clk(clk), .rdata(rdata), .req(req));
  orc_regs dut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .req(req), .resume_detected(resume_detected),
    .downstream_resume(downstream_resume), .status_irq(status_irq), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
    .sof_enable(sof_enable), .remote_wakeup(remote_wakeup), .host_irq(host_irq), .smi_irq(smi_irq));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d);
    cmp("read", e, d);
    cmp("rvalid", 32'h0000_0001, rvalid);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Ceiling sits above the 1 ms frame start wait
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      err_total++;
      end_sim;
    end
  end
  // ==========
  // Main sequence
  initial begin
    {rst_n, soft_reset, resume_detected, downstream_resume, status_irq} = '0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    rdc(REV_OFFSET, 32'h0000_0010);
    host.wr(REV_OFFSET, 32'h0000_00FF);
    rdc(REV_OFFSET, 32'h0000_0010);
    rdc(8'h08, 32'h0000_0000);
    host.wr(CTRL_OFFSET, 32'h0000_06BF);
    t0 = cyc;
    rdc(CTRL_OFFSET, 32'h0000_06BF);
    cmp("ctrl", 32'h0000_07F3, ctrl);
    resume_detected = 1;
    status_irq = 1;
    repeat (3) @(posedge clk);
    #1 cmp("flags", 4'h6, {sof_enable, remote_wakeup, host_irq, smi_irq});
    host.wr(CTRL_OFFSET, 32'h0000_03BF);
    repeat (3) @(posedge clk);
    #1 cmp("flags", 4'h1, {sof_enable, remote_wakeup, host_irq, smi_irq});
    for (int i = 0; i < 41000 && sof_enable !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("sof", 1, sof_enable);
    cmp("sof delay", SOF_DELAY_CYC, cyc - t0);
    soft_reset = 1;
    @(posedge clk) #1 soft_reset = 0;
    rdc(CTRL_OFFSET, 32'h0000_0300);
    downstream_resume = 1;
    host.wr(CTRL_OFFSET, 32'h0000_0000);
    rdc(CTRL_OFFSET, 32'h0000_0000);
    downstream_resume = 0;
    host.wr(CTRL_OFFSET, 32'h0000_02C0);
    @(posedge clk) #1 downstream_resume = 1;
    repeat (3) @(posedge clk);
    rdc(CTRL_OFFSET, 32'h0000_0240);
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    rdc(CTRL_OFFSET, 32'h0000_0000);
    end_sim;
  end
endmodule // tb
